// >>> pll_serial_control_port_bench.sv
// self-checking bench for the pll serial control port.
// assumes pscp_props is bound to pscp_top; pscp_host drives the link.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
	$display("Error %0t: got %h expected %h", $time, a, b); end end
module pll_serial_control_port_bench;
	import pscp_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, chip_select = 1'b1, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        serial_shift_clk, serial_window_select, serial_data_in;
	logic        register_readback_out, register_readback_oe_n;
	logic        pd_freeze_in = 1'b0, pd_freeze_driven = 1'b0;
	logic        counter_test_load_n = 1'b1, counter_test_load_driven = 1'b0;
	logic [5:0]  osc = 6'h0;
	logic        pd_out, divider_tap_out, osc_source_out, power_save_out;
	logic [64:0] exp_q[$];
	int          num_errors = 0, checked = 0, seed = 83788;
	logic [15:0] w, v;
	logic [2:0]  slow = 3'h0;
	logic        osc_run = 1'b1, osc_prev = 1'b0, counting = 1'b0;
	int          taps = 0, rises = 0;
	// a released readback pin shows the inverse of its last bit
	wire         sdo_pin = register_readback_out ^ register_readback_oe_n;
	pscp_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .serial_shift_clk, .serial_window_select,
		.serial_data_in, .register_readback_out, .register_readback_oe_n,
		.chip_select, .pd_freeze_in, .pd_freeze_driven, .counter_test_load_n,
		.counter_test_load_driven, .ext_osc_diff_pos_in(osc[0]),
		.ext_osc_diff_neg_in(osc[1]), .ext_osc_se_in(osc[2]),
		.line_pulse_diff_pos_in(osc[3]), .line_pulse_diff_neg_in(osc[4]),
		.line_pulse_se_in(osc[5]), .pd_out, .divider_tap_out,
		.osc_source_out, .power_save_out);
	pscp_host host (.sclk(serial_shift_clk), .win(serial_window_select),
		.sdi(serial_data_in), .sdo(sdo_pin));
	// ==========================================================
	// clock, and slow random oscillator and sync pins
	always #25 pclk = ~pclk;
	always @(posedge pclk) begin
		slow <= slow + 3'h1;
		if (slow == 3'h0)
			osc <= osc_run ? 6'($random(seed)) : 6'h0;
	end
	// tally tap pulses against rises of the routed single-ended pin
	always @(posedge pclk) begin
		osc_prev <= osc[2];
		if (counting) begin
			rises <= rises + int'(osc[2] & ~osc_prev);
			taps  <= taps + int'(divider_tap_out);
		end
	end
	// results: each finished read takes the oldest note {err, mask, data}
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite &&
		    exp_q.size() > 0) begin
			`CHK(pslverr, exp_q[0][64])
			`CHK(prdata & exp_q[0][63:32], exp_q[0][31:0])
			void'(exp_q.pop_front());
		end
	end
	// ==========================================================
	// apb master, verdict
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
			if (i == 15) begin
				num_errors++;
				test_done();
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m, input logic err);
		exp_q.push_back({err, m, e});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic test_done();
		$display("counts: %0d checked, %0d errors", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ==========================================================
	// main sequence; random words drawn before the pins start moving
	initial begin
		w = 16'($random(seed));
		v = 16'($random(seed));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(PSCP_LINK_CONFIG_OFS, 32'h1008, '1, 1'b0);
		rd(PSCP_STATUS_OFS, 32'h3, '1, 1'b0);
		rd(12'h010, 32'h0, '1, 1'b1);
		rd(12'h002, 32'h0, '1, 1'b1);
		apb(1'b1, PSCP_CONTROL_OFS, {16'h0, v});
		rd(PSCP_CONTROL_OFS, {30'h0, v[1:0]}, '1, 1'b0);
		$display("test map done");
		w[4:3] = 2'b01;
		host.wr(w, 16);
		repeat (8) @(posedge pclk);
		rd(PSCP_LINK_CONFIG_OFS, {16'h0, w & PSCP_CFG_WMASK}, '1, 1'b0);
		rd(PSCP_STATUS_OFS, 32'h7, 32'h1f, 1'b0);
		apb(1'b1, PSCP_STATUS_OFS, 32'h4);
		rd(PSCP_STATUS_OFS, 32'h3, 32'h1f, 1'b0);
		// partial frame, then a read that must not write
		host.wr(~w, 8);
		host.rd(v);
		`CHK(v, w & PSCP_CFG_WMASK)
		`CHK(register_readback_oe_n, 1'b0)
		rd(PSCP_LINK_CONFIG_OFS, {16'h0, w & PSCP_CFG_WMASK}, '1, 1'b0);
		host.wr(w & 16'hfff7, 16);
		host.rd(v);
		`CHK(register_readback_oe_n, 1'b1)
		$display("test serial done");
		@(posedge pclk);
		pd_freeze_driven <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(PSCP_STATUS_OFS, 32'h2, 32'h3, 1'b0);
		// counter test mode with each oscillator pin routed away
		apb(1'b1, PSCP_CONTROL_OFS, 32'h0);
		host.wr(16'h4019, 16);
		@(posedge pclk);
		counter_test_load_driven <= 1'b1;
		counter_test_load_n <= 1'b0;
		repeat (8) @(posedge pclk);
		rd(PSCP_COUNTER_OFS, 32'h40, 32'hff, 1'b0);
		`CHK(osc_source_out, 1'b0)
		apb(1'b1, PSCP_CONTROL_OFS, 32'h2);
		host.wr(16'h401a, 16);
		repeat (8) @(posedge pclk);
		`CHK(osc_source_out, 1'b0)
		// preset zero: every routed test pin rise reloads and taps
		osc_run <= 1'b0;
		host.wr(16'h001a, 16);
		repeat (16) @(posedge pclk);
		counter_test_load_n <= 1'b1;
		repeat (8) @(posedge pclk);
		counting <= 1'b1;
		osc_run <= 1'b1;
		repeat (200) @(posedge pclk);
		osc_run <= 1'b0;
		repeat (16) @(posedge pclk);
		counting <= 1'b0;
		@(posedge pclk);
		`CHK(rises != 0, 1'b1)
		`CHK(taps, rises)
		$display("test counter done");
		chip_select <= 1'b0;
		repeat (8) @(posedge pclk);
		rd(PSCP_STATUS_OFS, 32'h10, 32'h12, 1'b0);
		`CHK(power_save_out, 1'b1)
		chip_select <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(PSCP_LINK_CONFIG_OFS, 32'h001a, '1, 1'b0);
		$display("test power save done");
		test_done();
	end
endmodule

// >>> pscp_host.sv
// host-side model of the three-wire serial link.
// assumes it alone drives the link; the shift clock idles low.
`timescale 1ns/1ps
module pscp_host (
	output logic      sclk,
	output logic      win,
	output logic      sdi,
	input  wire logic sdo
);
	// ==========================================================
	// idle: clock stopped, window high so nothing half-written sticks
	initial begin
		sclk = 1'b0;
		win = 1'b1;
		sdi = 1'b0;
	end
	// one 125 ns bit; data settles well before the rise
	task automatic tick();
		#31.25 sclk = 1'b1;
		#62.5 sclk = 1'b0;
		#31.25;
	endtask
	// write frame of n bits, msb first; fewer than 16 is a partial frame
	task automatic wr(input logic [15:0] w, input int n);
		win = 1'b0;
		for (int k = 0; k < n; k++) begin
			sdi = w[15-k];
			tick();
		end
		sdi = ~sdi; // released line shows no stale bit
		win = 1'b1;
	endtask
	// read frame: bit 15-k is taken after falling edge k
	task automatic rd(output logic [15:0] v);
		win = 1'b1;
		for (int k = 0; k < 16; k++) begin
			tick();
			v[15-k] = sdo;
		end
	endtask
endmodule

// >>> pscp_pkg.sv
// shared constants for the pll serial control port: apb map, serial
// frame layout, configuration fields and values after reset.
// assumes a 32-bit apb3 bus and a 16-bit serial configuration word.
package pscp_pkg;

	// ==========================================================
	// apb register byte offsets
	localparam logic [11:0] PSCP_LINK_CONFIG_OFS = 12'h000;
	localparam logic [11:0] PSCP_STATUS_OFS      = 12'h004;
	localparam logic [11:0] PSCP_CONTROL_OFS     = 12'h008;
	localparam logic [11:0] PSCP_COUNTER_OFS     = 12'h00c;

	// ==========================================================
	// serial frame: bits per frame, sent most significant bit first
	localparam int          PSCP_FRAME_BITS = 16;
	localparam logic [3:0]  PSCP_LAST_BIT   = 4'hf;

	// configuration word fields
	localparam int PSCP_CFG_DIFF_ROUTE = 0;
	localparam int PSCP_CFG_SE_ROUTE   = 1;
	localparam int PSCP_CFG_SYNC_NEG   = 2;
	localparam int PSCP_CFG_RB_DRIVE   = 3;
	localparam int PSCP_CFG_TEST_MODE  = 4;
	localparam int PSCP_CFG_PRESET_LO  = 8;
	localparam logic [15:0] PSCP_CFG_RESET   = 16'h1008;
	localparam logic [15:0] PSCP_CFG_WMASK   = 16'hff1f;

	// ==========================================================
	// control register fields (written by software)
	localparam int PSCP_CTL_SYNC_SE = 0;
	localparam int PSCP_CTL_OSC_SE  = 1;
	localparam logic [1:0] PSCP_CTL_RESET = 2'h0;

	// status register fields
	localparam int PSCP_ST_FREEZE = 0;
	localparam int PSCP_ST_CS     = 1;
	localparam int PSCP_ST_FRAME  = 2;
	localparam int PSCP_ST_PD     = 3;
	localparam int PSCP_ST_PSAVE  = 4;

endpackage

// >>> pscp_props.sv
// concurrent checks on the pll serial control port pins, pclk domain.
// assumes it is bound to pscp_top and sees its ports only.
`timescale 1ns/1ps
module pscp_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        register_readback_oe_n,
	input wire logic        chip_select,
	input wire logic        pd_freeze_in,
	input wire logic        pd_freeze_driven,
	input wire logic        pd_out,
	input wire logic        divider_tap_out,
	input wire logic        power_save_out
);
	// ==========================================================
	// clocking and shared sequences
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic frz_eff;
	// an open freeze pin counts as high
	assign frz_eff = pd_freeze_in || !pd_freeze_driven;
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_bad;
		psel && !penable && (paddr[1:0] != 2'h0 || paddr > 12'h00c);
	endsequence
	// aligned and mapped: one of the four word offsets
	sequence s_good;
		psel && !penable && paddr[1:0] == 2'h0 && paddr <= 12'h00c;
	endsequence
	// ==========================================================
	// apb answer timing and refusal
	a_ready_next: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_once: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_bad: assert property (s_bad |=> pslverr)
		else $error("bad address not refused");
	a_err_good: assert property (s_good |=> !pslverr)
		else $error("good address refused");
	a_err_quiet: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("refused read returned data");
	// ==========================================================
	// power save, readback drive and freeze
	a_psave_on: assert property (
		$fell(chip_select) |-> ##[1:4] power_save_out)
		else $error("power save late");
	a_oe_off: assert property (
		!chip_select |-> register_readback_oe_n)
		else $error("readback driven in power save");
	// six cycles cover the two sync flops and the detector pipeline
	a_pd_hold: assert property (
		(frz_eff && chip_select)[*6] |-> $stable(pd_out))
		else $error("detector moved while frozen");
	a_tap_once: assert property (divider_tap_out |=> !divider_tap_out)
		else $error("tap pulse too long");
endmodule

bind pscp_top pscp_props u_props (.pclk, .presetn, .psel, .penable, .paddr,
	.prdata, .pready, .pslverr, .register_readback_oe_n, .chip_select,
	.pd_freeze_in, .pd_freeze_driven, .pd_out, .divider_tap_out,
	.power_save_out);

// >>> pscp_top.sv
// pll serial control port: three-wire serial register access on the
// link clock, sync and oscillator routing, programmable counter and a
// phase detector on pclk, and an apb3 window onto it all.
// assumes the host drives window select and data from its shift clock,
// and that the oscillator and sync pins toggle well below pclk / 4.
//
// What this block does
// - window select low writes registers, high reads them back.
// - with window select low, data bit captured on shift clock rise.
// - with window select high, readback bit changes on shift clock fall.
// - freeze input high holds phase detector output at its value.
// - an undriven freeze input counts as high, holding the detector.
// - in counter test mode, load low copies preset into the counter.
// - a config bit routes differential oscillator input to counter test.
// - a config bit routes single-ended oscillator input to counter test.
// - a config bit picks positive or negative sync polarity, both inputs.
// - chip select low puts the divider, detector, oscillator path and serial frame logic in power save.
// - a config bit switches readback output between driven and high-z.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps

module pscp_top #(
	parameter int CNT_W = 8
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb3 slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial link, all on serial_shift_clk
	input  wire logic        serial_shift_clk,
	input  wire logic        serial_window_select,
	input  wire logic        serial_data_in,
	output logic             register_readback_out,
	output logic             register_readback_oe_n,
	// asynchronous pins
	input  wire logic        chip_select,
	input  wire logic        pd_freeze_in,
	input  wire logic        pd_freeze_driven,
	input  wire logic        counter_test_load_n,
	input  wire logic        counter_test_load_driven,
	input  wire logic        ext_osc_diff_pos_in,
	input  wire logic        ext_osc_diff_neg_in,
	input  wire logic        ext_osc_se_in,
	input  wire logic        line_pulse_diff_pos_in,
	input  wire logic        line_pulse_diff_neg_in,
	input  wire logic        line_pulse_se_in,
	// towards the analog loop
	output logic             pd_out,
	output logic             divider_tap_out,
	output logic             osc_source_out,
	output logic             power_save_out
);
	import pscp_pkg::*;

	// ==========================================================
	// link domain state, rising edge of the shift clock
	typedef struct packed {
		logic [14:0] shift;
		logic [3:0]  cnt;
	} pscp_lshift_t;

	typedef struct packed {
		logic [15:0] cfg;
		logic        tog;
	} pscp_lcfg_t;

	// link domain state, falling edge of the shift clock
	typedef struct packed {
		logic [3:0] idx;
		logic       out;
		logic       oe_n;
	} pscp_lread_t;

	// pclk domain state; [0] is a synchroniser first stage
	typedef struct packed {
		logic [1:0]       cs;
		logic [1:0]       frz;
		logic [1:0]       frz_drv;
		logic [1:0]       ld;
		logic [1:0]       ld_drv;
		logic [1:0]       odp;
		logic [1:0]       odn;
		logic [1:0]       ose;
		logic [1:0]       lpp;
		logic [1:0]       lpn;
		logic [1:0]       lse;
		logic [1:0]       tog;
		logic             tog_prev;
		logic [15:0]      cfg;
		logic [1:0]       ctl;
		logic [CNT_W-1:0] count;
		logic             cnt_prev;
		logic             sync_prev;
		logic             pd;
		logic             tap;
		logic             osc;
		logic             psave;
		logic             frame_seen;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
	} pscp_core_t;

	pscp_lshift_t ls;
	pscp_lshift_t next_ls;
	pscp_lcfg_t   lc;
	pscp_lcfg_t   next_lc;
	pscp_lread_t  lr;
	pscp_lread_t  next_lr;
	pscp_core_t   st;
	pscp_core_t   next_st;

	// chip select low resets the frame logic outright; the link clock
	// may stand still, so a synchronised level could never act
	logic link_rst_n;
	assign link_rst_n = presetn & chip_select;

	// ==========================================================
	// serial write path: shift, count, commit on the last bit
	always_comb begin
		next_ls = ls;
		next_lc = lc;
		if (!serial_window_select) begin
			next_ls.shift = {ls.shift[13:0], serial_data_in};
			next_ls.cnt   = ls.cnt + 4'h1;
			if (ls.cnt == PSCP_LAST_BIT) begin
				// reserved bits never stick, so readback shows zero
				next_lc.cfg = {ls.shift, serial_data_in} & PSCP_CFG_WMASK;
				next_lc.tog = ~lc.tog;
				next_ls.cnt = 4'h0;
			end
		end else begin
			// a read frame discards any partial write frame
			next_ls.cnt = 4'h0;
		end
	end

	// frame logic drops a partial frame in power save
	always_ff @(posedge serial_shift_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ls <= '0;
		end else begin
			ls <= next_ls;
		end
	end

	// settings survive power save; only presetn clears them
	always_ff @(posedge serial_shift_clk or negedge presetn) begin
		if (!presetn) begin
			lc <= '{cfg: PSCP_CFG_RESET, tog: 1'b0};
		end else begin
			lc <= next_lc;
		end
	end

	// ==========================================================
	// serial read path: one bit per falling edge, msb first
	always_comb begin
		next_lr      = lr;
		next_lr.oe_n = ~lc.cfg[PSCP_CFG_RB_DRIVE];
		if (serial_window_select) begin
			next_lr.out = lc.cfg[PSCP_LAST_BIT - lr.idx];
			next_lr.idx = lr.idx + 4'h1;
		end else begin
			next_lr.idx = 4'h0;
		end
	end

	// power save leaves the readback pin undriven
	always_ff @(negedge serial_shift_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			lr <= '{idx: 4'h0, out: 1'b0, oe_n: 1'b1};
		end else begin
			lr <= next_lr;
		end
	end

	// ==========================================================
	// pclk core: synchronisers, routing, counter, detector, apb
	logic             frz_eff;
	logic             ld_eff_n;
	logic             osc_diff;
	logic             sync_lvl;
	logic             test_in;
	logic             osc_norm;
	logic             cnt_src;
	logic [CNT_W-1:0] preset;
	logic             setup;
	logic             access;
	logic [31:0]      rd;
	logic             bad;

	always_comb begin
		next_st = st;
		// second stages feed logic, first stages feed only second
		next_st.cs      = {st.cs[0], chip_select};
		next_st.frz     = {st.frz[0], pd_freeze_in};
		next_st.frz_drv = {st.frz_drv[0], pd_freeze_driven};
		next_st.ld      = {st.ld[0], counter_test_load_n};
		next_st.ld_drv  = {st.ld_drv[0], counter_test_load_driven};
		next_st.odp     = {st.odp[0], ext_osc_diff_pos_in};
		next_st.odn     = {st.odn[0], ext_osc_diff_neg_in};
		next_st.ose     = {st.ose[0], ext_osc_se_in};
		next_st.lpp     = {st.lpp[0], line_pulse_diff_pos_in};
		next_st.lpn     = {st.lpn[0], line_pulse_diff_neg_in};
		next_st.lse     = {st.lse[0], line_pulse_se_in};
		next_st.tog     = {st.tog[0], lc.tog};
		next_st.tog_prev = st.tog[1];

		// pins nobody drives rest high, as a pull-up would hold them
		frz_eff  = ~st.frz_drv[1] | st.frz[1];
		ld_eff_n = ~st.ld_drv[1] | st.ld[1];

		// settings word crosses by toggle; it is stable for a frame
		if (st.tog[1] != st.tog_prev) begin
			next_st.cfg        = lc.cfg;
			next_st.frame_seen = 1'b1;
		end

		// oscillator routing: a routed pin leaves the oscillator path
		osc_diff = st.odp[1] & ~st.odn[1];
		if (st.cfg[PSCP_CFG_DIFF_ROUTE]) begin
			test_in = osc_diff;
		end else if (st.cfg[PSCP_CFG_SE_ROUTE]) begin
			test_in = st.ose[1];
		end else begin
			test_in = 1'b0;
		end
		osc_norm = st.ctl[PSCP_CTL_OSC_SE] ? st.ose[1] : osc_diff;
		if (st.ctl[PSCP_CTL_OSC_SE] ? st.cfg[PSCP_CFG_SE_ROUTE]
		                            : st.cfg[PSCP_CFG_DIFF_ROUTE]) begin
			osc_norm = 1'b0;
		end
		cnt_src = st.cfg[PSCP_CFG_TEST_MODE] ? test_in : osc_norm;

		// sync source and polarity, same bit for both inputs
		sync_lvl = st.ctl[PSCP_CTL_SYNC_SE] ? st.lse[1]
		                                    : (st.lpp[1] & ~st.lpn[1]);
		sync_lvl = sync_lvl ^ st.cfg[PSCP_CFG_SYNC_NEG];

		// programmable divider: counts source edges down to zero
		preset = st.cfg[PSCP_CFG_PRESET_LO +: CNT_W];
		next_st.cnt_prev  = cnt_src;
		next_st.sync_prev = sync_lvl;
		next_st.tap       = 1'b0;
		if (st.cfg[PSCP_CFG_TEST_MODE] && !ld_eff_n) begin
			next_st.count = preset;
		end else if (cnt_src && !st.cnt_prev) begin
			if (st.count == '0) begin
				next_st.count = preset;
				next_st.tap   = 1'b1;
			end else begin
				next_st.count = st.count - 1'b1;
			end
		end

		// detector: at each sync edge, lead if past half the period
		if (sync_lvl && !st.sync_prev && !frz_eff) begin
			next_st.pd = (st.count < (preset >> 1));
		end
		next_st.osc   = osc_norm;
		next_st.psave = ~st.cs[1];

		// power save stops the divider, detector and oscillator path
		if (!st.cs[1]) begin
			next_st.count = '0;
			next_st.tap   = 1'b0;
			next_st.pd    = 1'b0;
			next_st.osc   = 1'b0;
		end

		// apb: decode in setup, answer in the first access cycle
		setup  = psel & ~penable;
		access = psel & penable & st.pready;
		rd     = 32'h0;
		bad    = (paddr[1:0] != 2'h0);
		case (paddr)
			PSCP_LINK_CONFIG_OFS: begin
				rd = {16'h0, st.cfg};
			end
			PSCP_STATUS_OFS: begin
				rd[PSCP_ST_FREEZE] = frz_eff;
				rd[PSCP_ST_CS]     = st.cs[1];
				rd[PSCP_ST_FRAME]  = st.frame_seen;
				rd[PSCP_ST_PD]     = st.pd;
				rd[PSCP_ST_PSAVE]  = st.psave;
			end
			PSCP_CONTROL_OFS: begin
				rd = {30'h0, st.ctl};
			end
			PSCP_COUNTER_OFS: begin
				rd[CNT_W-1:0] = st.count;
			end
			default: begin
				bad = 1'b1;
			end
		endcase
		next_st.pready  = setup;
		next_st.pslverr = setup & bad;
		if (setup) begin
			next_st.prdata = bad ? 32'h0 : rd;
		end
		if (access && pwrite && !st.pslverr) begin
			if (paddr == PSCP_CONTROL_OFS) begin
				next_st.ctl = pwdata[1:0];
			end
			// a new frame in the same cycle keeps the flag set
			if (paddr == PSCP_STATUS_OFS && pwdata[PSCP_ST_FRAME] &&
			    (st.tog[1] == st.tog_prev)) begin
				next_st.frame_seen = 1'b0;
			end
		end
	end

	// pclk state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st     <= '0;
			st.cfg <= PSCP_CFG_RESET;
			st.ctl <= PSCP_CTL_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs, each straight from a flip-flop
	assign prdata                 = st.prdata;
	assign pready                 = st.pready;
	assign pslverr                = st.pslverr;
	assign register_readback_out  = lr.out;
	assign register_readback_oe_n = lr.oe_n;
	assign pd_out                 = st.pd;
	assign divider_tap_out        = st.tap;
	assign osc_source_out         = st.osc;
	assign power_save_out         = st.psave;

endmodule
